/* core/adcsq_pkg.sv */
package adcsq_pkg;
  // Register map, byte addresses on the Wishbone bus: each 8-bit index sits at 4 * index
  localparam logic [7:0] ADCSQ_IDX_CONFIG   = 8'hb5; // Sequence configuration
  localparam logic [7:0] ADCSQ_IDX_STATUS   = 8'hb4; // Done flag, busy
  localparam logic [7:0] ADCSQ_IDX_RES_LOW  = 8'hba; // Result low byte
  localparam logic [7:0] ADCSQ_IDX_RES_HIGH = 8'hbb; // Result high byte
  localparam logic [7:0] ADCSQ_IDX_START    = 8'hb3; // Start and sample register
  localparam int         ADCSQ_ADDR_W       = 10;
  localparam logic [ADCSQ_ADDR_W-1:0] ADCSQ_ADDR_CONFIG   = {ADCSQ_IDX_CONFIG, 2'b00};
  localparam logic [ADCSQ_ADDR_W-1:0] ADCSQ_ADDR_STATUS   = {ADCSQ_IDX_STATUS, 2'b00};
  localparam logic [ADCSQ_ADDR_W-1:0] ADCSQ_ADDR_RES_LOW  = {ADCSQ_IDX_RES_LOW, 2'b00};
  localparam logic [ADCSQ_ADDR_W-1:0] ADCSQ_ADDR_RES_HIGH = {ADCSQ_IDX_RES_HIGH, 2'b00};
  localparam logic [ADCSQ_ADDR_W-1:0] ADCSQ_ADDR_START    = {ADCSQ_IDX_START, 2'b00};

  // Configuration and status field positions
  localparam int ADCSQ_REF_HI = 7;
  localparam int ADCSQ_REF_LO = 6;
  localparam int ADCSQ_DEC_HI = 5;
  localparam int ADCSQ_DEC_LO = 4;
  localparam int ADCSQ_CH_HI  = 3;
  localparam int ADCSQ_CH_LO  = 0;
  localparam int ADCSQ_DONE_BIT = 7;
  localparam int ADCSQ_BUSY_BIT = 6;
  localparam logic [7:0] ADCSQ_CONFIG_RESET = 8'h10;

  // Channel codes
  localparam logic [3:0] ADCSQ_CH_LAST_SE   = 4'h7;
  localparam logic [3:0] ADCSQ_CH_FIRST_DIF = 4'h8;
  localparam logic [3:0] ADCSQ_CH_LAST_DIF  = 4'hb;

  // Timing: 100 MHz system clock, 4 MHz converter clock
  localparam int ADCSQ_SYS_HZ      = 100_000_000;
  localparam int ADCSQ_CONV_HZ     = 4_000_000;
  localparam int ADCSQ_CONV_DIV    = ADCSQ_SYS_HZ / ADCSQ_CONV_HZ;
  localparam int ADCSQ_SETTLE_TICKS = 16;
  localparam int ADCSQ_CNT_W       = 10;

  typedef enum logic [1:0] {
    ADCSQ_IDLE   = 2'b00,
    ADCSQ_SETTLE = 2'b01,
    ADCSQ_DECIM  = 2'b10
  } adcsq_state_t;

  // Decimation code to number of converter clock periods
  function automatic logic [ADCSQ_CNT_W-1:0] adcsq_dec_ticks(input logic [1:0] code);
    adcsq_dec_ticks = ADCSQ_CNT_W'(64) << code;
  endfunction

  // Decimation code to result width in bits
  function automatic logic [3:0] adcsq_res_bits(input logic [1:0] code);
    case (code)
      2'b00:   adcsq_res_bits = 4'h8;
      2'b01:   adcsq_res_bits = 4'ha;
      2'b10:   adcsq_res_bits = 4'hc;
      default: adcsq_res_bits = 4'hd;
    endcase
  endfunction
endpackage

/* core/adcsq_tick_div.sv */
`timescale 1ns/1ns
`default_nettype none
module adcsq_tick_div
  import adcsq_pkg::*;
#(
  parameter int DIV = ADCSQ_CONV_DIV
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } adcsq_div_t;
  adcsq_div_t st_reg;
  adcsq_div_t st_next;

  // Free running divider; one-cycle pulse per converter clock period
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 8'(DIV - 1)) begin
      st_next.cnt  = 8'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;

  a_tick_period: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(tick_o) |-> ##1 !tick_o [*8] ##1 !tick_o [*8] ##1 !tick_o [*8] ##1 tick_o)
    else $error("converter tick period wrong");
endmodule // adcsq_tick_div
`default_nettype wire

/* core/adcsq_wb_slave.sv */
`timescale 1ns/1ns
`default_nettype none
module adcsq_wb_slave
  import adcsq_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [ADCSQ_ADDR_W-1:0] adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic                         ack_o,
  output logic                         wr_o,
  output logic                         rd_o,
  output logic [ADCSQ_ADDR_W-1:0]      adr_o,
  output logic [7:0]                   wdata_o
);
  typedef struct packed {
    logic ack;
  } adcsq_wb_t;
  adcsq_wb_t st_reg;
  adcsq_wb_t st_next;

  // One wait state: ack one cycle after the request, dropped in the next
  always_comb begin
    st_next = st_reg;
    st_next.ack = cyc_i && stb_i && !st_reg.ack;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Strobes fire at the acking edge; writes need lane 0 since data is eight bits
  assign ack_o   = st_reg.ack;
  assign wr_o    = st_reg.ack && cyc_i && stb_i && we_i && sel_i[0];
  assign rd_o    = st_reg.ack && cyc_i && stb_i && !we_i;
  assign adr_o   = adr_i;
  assign wdata_o = dat_i[7:0];

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
endmodule // adcsq_wb_slave
`default_nettype wire

/* core/adcsq_seq_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Bits 7:6 pick the sequence reference: internal 1.25 V, input 7, supply pin, or inputs 6-7.
// - Bits 5:4, reset 01, set decimation 64/128/256/512 for 8/10/12/13 bits of resolution.
// - An end code of 7 or less converts single-ended inputs 0 up to that input in order.
// - End codes 8 to 11 convert differential pairs from 0-1 up to the selected pair in order.
// - End codes 12 to 15 give a lone conversion of ground, reference, temperature or supply/3.
// - Reading the channel field returns the channel of the result now held.
// - The done flag stays set until both result bytes are read, even if a newer result lands.
// - Each conversion takes 16 converter clocks of settling plus the decimation count.
module adcsq_seq_ctrl
  import adcsq_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [ADCSQ_ADDR_W-1:0] adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic [31:0]                  dat_o,
  output logic                         ack_o,
  input  wire logic [13:0]             sample_i,
  output logic [1:0]                   ref_sel_o,
  output logic [3:0]                   mux_ch_o,
  output logic [3:0]                   res_bits_o,
  output logic                         busy_o
);
  typedef struct packed {
    logic [1:0]             ref_sel;
    logic [1:0]             dec_sel;
    logic [3:0]             end_ch;
    logic [3:0]             cur_ch;
    logic [3:0]             res_ch;
    logic [13:0]            result;
    logic                   done;
    logic                   low_read;
    logic                   high_read;
    adcsq_state_t           state;
    logic [ADCSQ_CNT_W-1:0] cnt;
    logic [31:0]            rdata;
  } adcsq_st_t;
  adcsq_st_t st_reg;
  adcsq_st_t st_next;

  logic                    tick;
  logic                    wr;
  logic                    rd;
  logic [ADCSQ_ADDR_W-1:0] adr;
  logic [7:0]              wdata;
  logic                    start;
  logic                    conv_end;

  adcsq_tick_div #(
    .DIV (ADCSQ_CONV_DIV)
  ) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  adcsq_wb_slave u_wb (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cyc_i   (cyc_i),
    .stb_i   (stb_i),
    .we_i    (we_i),
    .adr_i   (adr_i),
    .sel_i   (sel_i),
    .dat_i   (dat_i),
    .ack_o   (ack_o),
    .wr_o    (wr),
    .rd_o    (rd),
    .adr_o   (adr),
    .wdata_o (wdata)
  );

  // First channel of a run: input 0, pair 0-1, or the lone special source
  function automatic logic [3:0] first_ch(input logic [3:0] e);
    if (e <= ADCSQ_CH_LAST_SE) begin
      first_ch = 4'h0;
    end else if (e <= ADCSQ_CH_LAST_DIF) begin
      first_ch = ADCSQ_CH_FIRST_DIF;
    end else begin
      first_ch = e;
    end
  endfunction

  assign start    = wr && (adr == ADCSQ_ADDR_START) && wdata[0];
  assign conv_end = (st_reg.state == ADCSQ_DECIM) && tick && (st_reg.cnt == '0);

  // Register file, sequencer and result capture
  always_comb begin
    st_next = st_reg;
    // Configuration write; the channel field written sets the sequence end
    if (wr && adr == ADCSQ_ADDR_CONFIG) begin
      st_next.ref_sel = wdata[ADCSQ_REF_HI:ADCSQ_REF_LO];
      st_next.dec_sel = wdata[ADCSQ_DEC_HI:ADCSQ_DEC_LO];
      st_next.end_ch  = wdata[ADCSQ_CH_HI:ADCSQ_CH_LO];
    end
    // Result byte reads mark the pair as consumed
    if (rd && adr == ADCSQ_ADDR_RES_LOW) begin
      st_next.low_read = 1'b1;
    end
    if (rd && adr == ADCSQ_ADDR_RES_HIGH) begin
      st_next.high_read = 1'b1;
    end
    if (st_next.low_read && st_next.high_read) begin
      st_next.done      = 1'b0;
      st_next.low_read  = 1'b0;
      st_next.high_read = 1'b0;
    end
    unique case (st_reg.state)
      ADCSQ_IDLE: begin
        if (start) begin
          st_next.cur_ch = first_ch(st_reg.end_ch);
          st_next.cnt    = ADCSQ_CNT_W'(ADCSQ_SETTLE_TICKS - 1);
          st_next.state  = ADCSQ_SETTLE;
        end
      end
      ADCSQ_SETTLE: begin
        // Settling is the same 16 ticks at every rate
        if (tick) begin
          if (st_reg.cnt == '0) begin
            st_next.cnt   = adcsq_dec_ticks(st_reg.dec_sel) - ADCSQ_CNT_W'(1);
            st_next.state = ADCSQ_DECIM;
          end else begin
            st_next.cnt = st_reg.cnt - ADCSQ_CNT_W'(1);
          end
        end
      end
      ADCSQ_DECIM: begin
        if (tick && st_reg.cnt != '0) begin
          st_next.cnt = st_reg.cnt - ADCSQ_CNT_W'(1);
        end
        if (conv_end) begin
          // New result wins over a read clearing the flag in the same cycle
          st_next.result    = sample_i;
          st_next.res_ch    = st_reg.cur_ch;
          st_next.done      = 1'b1;
          st_next.low_read  = 1'b0;
          st_next.high_read = 1'b0;
          if (st_reg.cur_ch >= st_reg.end_ch) begin
            st_next.state = ADCSQ_IDLE;
          end else begin
            st_next.cur_ch = st_reg.cur_ch + 4'h1;
            st_next.cnt    = ADCSQ_CNT_W'(ADCSQ_SETTLE_TICKS - 1);
            st_next.state  = ADCSQ_SETTLE;
          end
        end
      end
      default: begin
        st_next.state = ADCSQ_IDLE;
      end
    endcase
    // Read mux; unmapped addresses read zero
    st_next.rdata = 32'h0000_0000;
    if (cyc_i && stb_i && !we_i) begin
      unique case (adr_i)
        ADCSQ_ADDR_CONFIG:   st_next.rdata = {24'h0, st_reg.ref_sel, st_reg.dec_sel,
                                              st_reg.res_ch};
        ADCSQ_ADDR_STATUS:   st_next.rdata = {24'h0, st_reg.done,
                                              st_reg.state != ADCSQ_IDLE, 6'h00};
        ADCSQ_ADDR_RES_LOW:  st_next.rdata = {24'h0, st_reg.result[5:0], 2'b00};
        ADCSQ_ADDR_RES_HIGH: st_next.rdata = {24'h0, st_reg.result[13:6]};
        default:             st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Synchronous reset to the power-on configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg         <= '0;
      st_reg.ref_sel <= ADCSQ_CONFIG_RESET[ADCSQ_REF_HI:ADCSQ_REF_LO];
      st_reg.dec_sel <= ADCSQ_CONFIG_RESET[ADCSQ_DEC_HI:ADCSQ_DEC_LO];
      st_reg.end_ch  <= ADCSQ_CONFIG_RESET[ADCSQ_CH_HI:ADCSQ_CH_LO];
      st_reg.res_ch  <= ADCSQ_CONFIG_RESET[ADCSQ_CH_HI:ADCSQ_CH_LO];
      st_reg.state   <= ADCSQ_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read data is registered with ack, so it is valid on the acking edge
  assign dat_o      = st_reg.rdata;
  assign ref_sel_o  = st_reg.ref_sel;
  assign mux_ch_o   = st_reg.cur_ch;
  assign res_bits_o = adcsq_res_bits(st_reg.dec_sel);
  assign busy_o     = st_reg.state != ADCSQ_IDLE;

  // Helper: converter ticks spent in the current conversion
  logic [ADCSQ_CNT_W:0] tick_seen;
  always_ff @(posedge clk_i) begin
    if (rst_i || st_reg.state == ADCSQ_IDLE || conv_end) begin
      tick_seen <= '0;
    end else if (tick) begin
      tick_seen <= tick_seen + (ADCSQ_CNT_W+1)'(1);
    end
  end

  // Helper: converter ticks spent while settling, kept apart from the decimation count
  logic [4:0] settle_seen;
  always_ff @(posedge clk_i) begin
    if (rst_i || st_reg.state != ADCSQ_SETTLE) begin
      settle_seen <= '0;
    end else if (tick) begin
      settle_seen <= settle_seen + 5'h01;
    end
  end

  // Steps of one conversion; the decimation load uses the rate seen at the settling edge
  sequence s_settle_armed;
    st_reg.state == ADCSQ_SETTLE && st_reg.cnt == ADCSQ_CNT_W'(ADCSQ_SETTLE_TICKS - 1);
  endsequence
  sequence s_settle_end;
    st_reg.state == ADCSQ_SETTLE && tick && st_reg.cnt == '0;
  endsequence
  sequence s_decim_armed;
    st_reg.state == ADCSQ_DECIM
    && st_reg.cnt == adcsq_dec_ticks($past(st_reg.dec_sel)) - ADCSQ_CNT_W'(1);
  endsequence

  // Conversion timing; a rate change in mid-conversion is not covered here
  a_conv_length: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_end |-> tick_seen == (ADCSQ_CNT_W+1)'(ADCSQ_SETTLE_TICKS - 1)
                 + {1'b0, adcsq_dec_ticks(st_reg.dec_sel)})
    else $error("conversion length wrong");
  a_start_settle: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == ADCSQ_IDLE && start) |=> s_settle_armed)
    else $error("settling count not loaded");
  a_settle_len: assert property (@(posedge clk_i) disable iff (rst_i)
    s_settle_end |-> settle_seen == 5'(ADCSQ_SETTLE_TICKS - 1))
    else $error("settling time wrong");
  a_settle_decim: assert property (@(posedge clk_i) disable iff (rst_i)
    s_settle_end |=> s_decim_armed)
    else $error("decimation count not loaded");

  // Done flag and result capture; a newer result keeps the flag up
  a_done_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.done && !(rd && (adr == ADCSQ_ADDR_RES_LOW || adr == ADCSQ_ADDR_RES_HIGH))
    |=> st_reg.done)
    else $error("done flag fell without a read");
  a_done_newer: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_end && st_reg.done) |=> st_reg.done)
    else $error("newer result cleared the done flag");
  a_done_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.done && !conv_end && rd
     && ((st_reg.low_read && adr == ADCSQ_ADDR_RES_HIGH)
      || (st_reg.high_read && adr == ADCSQ_ADDR_RES_LOW))) |=> !st_reg.done)
    else $error("done flag stayed after both bytes");
  a_done_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_end |=> st_reg.done && st_reg.res_ch == $past(st_reg.cur_ch))
    else $error("result channel not captured");
  a_config_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !we_i && adr_i == ADCSQ_ADDR_CONFIG)
    |=> dat_o[ADCSQ_CH_HI:ADCSQ_CH_LO] == $past(st_reg.res_ch))
    else $error("channel field read wrong");
  a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !we_i && adr_i == ADCSQ_ADDR_STATUS)
    |=> dat_o[ADCSQ_BUSY_BIT] == $past(busy_o)
    && dat_o[ADCSQ_DONE_BIT] == $past(st_reg.done))
    else $error("status read wrong");
  a_low_bytes: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !we_i && adr_i == ADCSQ_ADDR_RES_LOW)
    |=> dat_o[7:0] == {$past(st_reg.result[5:0]), 2'b00})
    else $error("low result byte misaligned");

  // Reset and configuration fields
  a_reset_value: assert property (@(posedge clk_i)
    rst_i |=> {st_reg.ref_sel, st_reg.dec_sel, st_reg.res_ch} == ADCSQ_CONFIG_RESET)
    else $error("configuration reset wrong");
  a_ref_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr == ADCSQ_ADDR_CONFIG) |=> ref_sel_o == $past(wdata[7:6])
    && res_bits_o == adcsq_res_bits($past(wdata[5:4])))
    else $error("configuration write lost");
  a_ref_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && adr == ADCSQ_ADDR_CONFIG) |=> $stable(ref_sel_o) && $stable(res_bits_o))
    else $error("configuration moved without a write");
  a_res_width: assert property (@(posedge clk_i) disable iff (rst_i)
    res_bits_o == (st_reg.dec_sel == 2'b00 ? 4'h8 : st_reg.dec_sel == 2'b01 ? 4'ha
                   : st_reg.dec_sel == 2'b10 ? 4'hc : 4'hd))
    else $error("resolution does not match rate");

  // Channel order within a run; a start while busy must not disturb the channel
  a_start_first: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == ADCSQ_IDLE && start) |=> mux_ch_o == first_ch($past(st_reg.end_ch)))
    else $error("sequence began at wrong channel");
  a_start_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == ADCSQ_IDLE && start) |=> busy_o)
    else $error("start did not begin a run");
  a_next_channel: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_end && st_reg.cur_ch < st_reg.end_ch)
    |=> busy_o && mux_ch_o == $past(st_reg.cur_ch) + 4'h1)
    else $error("run skipped a channel");
  a_mux_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    (busy_o && !conv_end) |=> $stable(mux_ch_o))
    else $error("channel moved inside a conversion");
  a_diff_range: assert property (@(posedge clk_i) disable iff (rst_i)
    (busy_o && st_reg.end_ch >= ADCSQ_CH_FIRST_DIF && st_reg.end_ch <= ADCSQ_CH_LAST_DIF
     && !$changed(st_reg.end_ch)) |-> mux_ch_o >= ADCSQ_CH_FIRST_DIF)
    else $error("differential run left pair range");
  a_lone_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_end && st_reg.cur_ch > ADCSQ_CH_LAST_DIF) |=> !busy_o)
    else $error("special source did not stop");
  a_run_end: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_end && st_reg.cur_ch >= st_reg.end_ch) |=> !busy_o)
    else $error("run went past its end");
endmodule // adcsq_seq_ctrl
`default_nettype wire

/* bench/tb_adc_sequence_control.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_adc_sequence_control import adcsq_pkg::*;;
  logic                    clk_i    = 1'b0;
  logic                    rst_i    = 1'b1;
  logic                    cyc_i    = 1'b0;
  logic                    stb_i    = 1'b0;
  logic                    we_i     = 1'b0;
  logic [ADCSQ_ADDR_W-1:0] adr_i    = '0;
  logic [3:0]              sel_i    = 4'h0;
  logic [31:0]             dat_i    = 32'h0;
  logic [13:0]             sample_i = 14'h2a5b;
  logic [31:0]             dat_o;
  logic                    ack_o;
  logic [1:0]              ref_sel_o;
  logic [3:0]              mux_ch_o;
  logic [3:0]              res_bits_o;
  logic                    busy_o;
  logic [7:0]              q;
  logic [3:0]              seen[$];
  logic [3:0]              res_tab[4] = '{4'h8, 4'ha, 4'hc, 4'hd};
  int                      miscompares = 0;
  int                      n_checks = 0;
  adcsq_seq_ctrl adcsq_seq_ctrl_i (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cyc_i      (cyc_i),
    .stb_i      (stb_i),
    .we_i       (we_i),
    .adr_i      (adr_i),
    .sel_i      (sel_i),
    .dat_i      (dat_i),
    .dat_o      (dat_o),
    .ack_o      (ack_o),
    .sample_i   (sample_i),
    .ref_sel_o  (ref_sel_o),
    .mux_ch_o   (mux_ch_o),
    .res_bits_o (res_bits_o),
    .busy_o     (busy_o)
  );

  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; the request stands untouched until ack is sampled high
  task automatic wb(input logic w, input logic [ADCSQ_ADDR_W-1:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= {24'h0, d};
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  // Start a run and log each channel as it appears; first span is partial, so skipped
  task automatic run(input logic [3:0] last, input logic [3:0] first, input logic [1:0] dec);
    int n;
    int t;
    int span;
    // One conversion at the chosen rate, in system clocks
    span = (ADCSQ_SETTLE_TICKS + (64 << dec)) * ADCSQ_CONV_DIV;
    seen.delete();
    wb(1'b1, ADCSQ_ADDR_CONFIG, {2'b00, dec, last}, q);
    wb(1'b1, ADCSQ_ADDR_START, 8'h01, q);
    wb(1'b0, ADCSQ_ADDR_STATUS, 8'h00, q);
    chk(32'(q[ADCSQ_BUSY_BIT]), 32'h1);
    chk(32'(res_bits_o), 32'(res_tab[dec]));
    n = 0;
    t = 0;
    while (busy_o === 1'b1 && n < 40000) begin
      if (seen.size() == 0 || mux_ch_o !== seen[$]) begin
        if (seen.size() > 1) chk(32'(t > span - 3 && t < span + 3), 32'h1);
        seen.push_back(mux_ch_o);
        t = 0;
      end
      @(posedge clk_i);
      n++;
      t++;
    end
    chk(32'(n < 40000), 32'h1);
    chk(32'(seen.size()), 32'(last - first + 4'h1));
    foreach (seen[i]) chk(32'(seen[i]), 32'(first + 4'(i)));
  endtask

  task automatic test_done();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard, about twice the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADCSQ_ADDR_CONFIG, 8'h00, q);
    chk(32'(q), 32'h10);
    chk(32'(res_bits_o), 32'ha);
    chk(32'(ref_sel_o), 32'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ADCSQ_ADDR_CONFIG, {2'(i), 2'(i), 4'h0}, q);
      wb(1'b0, ADCSQ_ADDR_CONFIG, 8'h00, q);
      chk(32'(q), 32'({2'(i), 2'(i), 4'h0}));
      chk(32'(ref_sel_o), 32'(i));
      chk(32'(res_bits_o), 32'(res_tab[i]));
    end
    // Unmapped place reads as zero and is still answered
    wb(1'b0, 10'h3fc, 8'h00, q);
    chk(32'(q), 32'h0);
    run(4'h2, 4'h0, 2'h1);
    wb(1'b0, ADCSQ_ADDR_CONFIG, 8'h00, q);
    chk(32'(q[3:0]), 32'h2);
    wb(1'b0, ADCSQ_ADDR_STATUS, 8'h00, q);
    chk(32'(q[ADCSQ_DONE_BIT]), 32'h1);
    wb(1'b0, ADCSQ_ADDR_RES_HIGH, 8'h00, q);
    chk(32'(q), 32'(sample_i[13:6]));
    wb(1'b0, ADCSQ_ADDR_STATUS, 8'h00, q);
    chk(32'(q[ADCSQ_DONE_BIT]), 32'h1);
    wb(1'b0, ADCSQ_ADDR_RES_LOW, 8'h00, q);
    chk(32'(q), 32'({sample_i[5:0], 2'b00}));
    wb(1'b0, ADCSQ_ADDR_STATUS, 8'h00, q);
    chk(32'(q[ADCSQ_DONE_BIT]), 32'h0);
    chk(32'(q[ADCSQ_BUSY_BIT]), 32'h0);
    run(4'h9, 4'h8, 2'h0);
    wb(1'b0, ADCSQ_ADDR_CONFIG, 8'h00, q);
    chk(32'(q[3:0]), 32'h9);
    run(4'hd, 4'hd, 2'h3);
    wb(1'b0, ADCSQ_ADDR_CONFIG, 8'h00, q);
    chk(32'(q[3:0]), 32'hd);
    test_done();
  end
endmodule // tb_adc_sequence_control
`default_nettype wire
